/* pgo_pattern_output.v */
// How it works
// - Enabled bit copies staged data on trigger
// - Disabled bit keeps pin, no copy
// - Low-byte enables reset zero, read/write
// - Shared 2/3 trigger: byte at A4, A6 ones
// - Separate 2/3: group 3 high nibble A4
// - Shared 0/1 trigger: byte at A5, A7 ones
// - Separate 0/1: group 1 high nibble A5
// - Low staging: group 1 high, group 0 low
// - Normal mode updates at selected match A
// - Two-bit channel select per group, reset ones
// - Non-overlap uses both match A and B
//
// Added by the designer: strobed register access.

`include "pgo_defines.vh"

module pgo_pattern_output (
    // Clock and reset
    input wire clock,
    input wire srst,
    // Register port
    input wire [15:0] addr,
    input wire [7:0] wr_data,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rd_data_ff,
    // Timer compare matches, one bit per channel
    input wire [3:0] cmp_a,
    input wire [3:0] cmp_b,
    // Pattern pins
    output wire [7:0] port_a_pin,
    output wire [7:0] port_b_pin,
    output wire [7:0] port_a_oe,
    output wire [7:0] port_b_oe
);

    // ------------------------------------------------------------
    // Staging layout helpers
    // ------------------------------------------------------------
    // Byte or nibble write, per pair layout
    function [7:0] stage_write;
        input [7:0] old;
        input [7:0] data;
        input shared;
        input hit_main;
        input hit_comp;
        begin
            stage_write = old;
            if (shared) begin
                if (hit_main) begin
                    stage_write = data;
                end
            end else begin
                if (hit_main) begin
                    stage_write[`PGO_NIB_HI] = data[`PGO_NIB_HI];
                end
                if (hit_comp) begin
                    stage_write[`PGO_NIB_LO] = data[`PGO_NIB_LO];
                end
            end
        end
    endfunction

    // Unused bits read as ones
    function [7:0] stage_read;
        input [7:0] val;
        input shared;
        input is_comp;
        begin
            if (shared) begin
                stage_read = is_comp ? `PGO_UNUSED : val;
            end else if (is_comp) begin
                stage_read = {`PGO_NIB_ONES, val[`PGO_NIB_LO]};
            end else begin
                stage_read = {val[`PGO_NIB_HI], `PGO_NIB_ONES};
            end
        end
    endfunction

    // Full 16-bit match, no partial decode
    function addr_is;
        input [15:0] a;
        input [15:0] target;
        begin
            addr_is = (a == target);
        end
    endfunction

    // Two groups share a trigger when they pick one channel
    function same_trig;
        input [1:0] sel_x;
        input [1:0] sel_y;
        begin
            same_trig = (sel_x == sel_y);
        end
    endfunction

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    reg [3:0] mode_ff;
    reg [7:0] trig_ff;
    reg [7:0] en_a_ff;
    reg [7:0] en_b_ff;
    reg [7:0] nxt_hi_ff;
    reg [7:0] nxt_lo_ff;
    reg [7:0] nxt_rd_data;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire hit_mode = addr_is(addr, `PGO_ADDR_MODE);
    wire hit_trig = addr_is(addr, `PGO_ADDR_TRIG);
    wire hit_enb = addr_is(addr, `PGO_ADDR_ENB);
    wire hit_ena = addr_is(addr, `PGO_ADDR_ENA);
    wire hit_nxb_a = addr_is(addr, `PGO_ADDR_NXB_A);
    wire hit_nxa_a = addr_is(addr, `PGO_ADDR_NXA_A);
    wire hit_nxb_b = addr_is(addr, `PGO_ADDR_NXB_B);
    wire hit_nxa_b = addr_is(addr, `PGO_ADDR_NXA_B);

    // Either address of a staging pair
    wire hit_hi_stage = hit_nxb_a | hit_nxb_b;
    wire hit_lo_stage = hit_nxa_a | hit_nxa_b;

    // ------------------------------------------------------------
    // Trigger select fields
    // ------------------------------------------------------------
    wire [1:0] sel_g0 = trig_ff[`PGO_SEL_G0];
    wire [1:0] sel_g1 = trig_ff[`PGO_SEL_G1];
    wire [1:0] sel_g2 = trig_ff[`PGO_SEL_G2];
    wire [1:0] sel_g3 = trig_ff[`PGO_SEL_G3];

    // Pair layout follows the channel selects
    wire shared_hi = same_trig(sel_g2, sel_g3);
    wire shared_lo = same_trig(sel_g0, sel_g1);

    // ------------------------------------------------------------
    // Non-overlap mode register
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (srst) begin
            mode_ff <= `PGO_RST_MODE;
        end else if (wr_stb & hit_mode) begin
            mode_ff <= wr_data[`PGO_NIB_LO];
        end
    end

    // ------------------------------------------------------------
    // Trigger select register
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (srst) begin
            trig_ff <= `PGO_RST_TRIG;
        end else if (wr_stb & hit_trig) begin
            trig_ff <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Output enable registers
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (srst) begin
            en_a_ff <= `PGO_RST_EN;
        end else if (wr_stb & hit_ena) begin
            en_a_ff <= wr_data;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            en_b_ff <= `PGO_RST_EN;
        end else if (wr_stb & hit_enb) begin
            en_b_ff <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Staging registers
    // ------------------------------------------------------------
    // Companion writes land only in the separate layout
    always @(posedge clock) begin
        if (srst) begin
            nxt_hi_ff <= `PGO_RST_NXT;
        end else if (wr_stb) begin
            nxt_hi_ff <= stage_write(nxt_hi_ff, wr_data, shared_hi,
                                     hit_nxb_a, hit_nxb_b);
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            nxt_lo_ff <= `PGO_RST_NXT;
        end else if (wr_stb) begin
            nxt_lo_ff <= stage_write(nxt_lo_ff, wr_data, shared_lo,
                                     hit_nxa_a, hit_nxa_b);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @* begin
        nxt_rd_data = `PGO_RD_IDLE;
        if (rd_stb) begin
            if (hit_mode) begin
                nxt_rd_data = {`PGO_MODE_RSVD, mode_ff};
            end else if (hit_trig) begin
                nxt_rd_data = trig_ff;
            end else if (hit_ena) begin
                nxt_rd_data = en_a_ff;
            end else if (hit_enb) begin
                nxt_rd_data = en_b_ff;
            end else if (hit_hi_stage) begin
                nxt_rd_data = stage_read(nxt_hi_ff, shared_hi, hit_nxb_b);
            end else if (hit_lo_stage) begin
                nxt_rd_data = stage_read(nxt_lo_ff, shared_lo, hit_nxa_b);
            end else begin
                nxt_rd_data = `PGO_UNUSED;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (srst) begin
            rd_data_ff <= `PGO_RD_IDLE;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Trigger selection and output groups
    // ------------------------------------------------------------
    wire trig_a_g0;
    wire trig_b_g0;
    wire trig_a_g1;
    wire trig_b_g1;
    wire trig_a_g2;
    wire trig_b_g2;
    wire trig_a_g3;
    wire trig_b_g3;
    wire nov_g0 = mode_ff[`PGO_NOV_G0];
    wire nov_g1 = mode_ff[`PGO_NOV_G1];
    wire nov_g2 = mode_ff[`PGO_NOV_G2];
    wire nov_g3 = mode_ff[`PGO_NOV_G3];
    wire [15:0] nxt_all = {nxt_hi_ff, nxt_lo_ff};
    wire [15:0] en_all = {en_b_ff, en_a_ff};
    wire [15:0] pin_all;

    // Group 0, low byte lower pins
    pgo_trig_sel u_sel_g0 (
        .sel(sel_g0),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .trig_a(trig_a_g0),
        .trig_b(trig_b_g0)
    );

    pgo_group u_grp_g0 (
        .clock(clock),
        .srst(srst),
        .nxt_data(nxt_all[`PGO_GRP0]),
        .enable(en_all[`PGO_GRP0]),
        .nonoverlap(nov_g0),
        .trig_a(trig_a_g0),
        .trig_b(trig_b_g0),
        .pin_ff(pin_all[`PGO_GRP0])
    );

    // Group 1, low byte upper pins
    pgo_trig_sel u_sel_g1 (
        .sel(sel_g1),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .trig_a(trig_a_g1),
        .trig_b(trig_b_g1)
    );

    pgo_group u_grp_g1 (
        .clock(clock),
        .srst(srst),
        .nxt_data(nxt_all[`PGO_GRP1]),
        .enable(en_all[`PGO_GRP1]),
        .nonoverlap(nov_g1),
        .trig_a(trig_a_g1),
        .trig_b(trig_b_g1),
        .pin_ff(pin_all[`PGO_GRP1])
    );

    // Group 2, high byte lower pins
    pgo_trig_sel u_sel_g2 (
        .sel(sel_g2),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .trig_a(trig_a_g2),
        .trig_b(trig_b_g2)
    );

    pgo_group u_grp_g2 (
        .clock(clock),
        .srst(srst),
        .nxt_data(nxt_all[`PGO_GRP2]),
        .enable(en_all[`PGO_GRP2]),
        .nonoverlap(nov_g2),
        .trig_a(trig_a_g2),
        .trig_b(trig_b_g2),
        .pin_ff(pin_all[`PGO_GRP2])
    );

    // Group 3, high byte upper pins
    pgo_trig_sel u_sel_g3 (
        .sel(sel_g3),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .trig_a(trig_a_g3),
        .trig_b(trig_b_g3)
    );

    pgo_group u_grp_g3 (
        .clock(clock),
        .srst(srst),
        .nxt_data(nxt_all[`PGO_GRP3]),
        .enable(en_all[`PGO_GRP3]),
        .nonoverlap(nov_g3),
        .trig_a(trig_a_g3),
        .trig_b(trig_b_g3),
        .pin_ff(pin_all[`PGO_GRP3])
    );

    // ------------------------------------------------------------
    // Pin and enable outputs
    // ------------------------------------------------------------
    assign port_a_pin = pin_all[`PGO_BYTE_LO];
    assign port_b_pin = pin_all[`PGO_BYTE_HI];
    assign port_a_oe = en_a_ff;
    assign port_b_oe = en_b_ff;

endmodule // pgo_pattern_output

/* pgo_defines.vh */
`ifndef PGO_DEFINES_VH
`define PGO_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PGO_ADDR_MODE 16'h00a0
`define PGO_ADDR_TRIG 16'h00a1
`define PGO_ADDR_ENB 16'h00a2
`define PGO_ADDR_ENA 16'h00a3
`define PGO_ADDR_NXB_A 16'hffa4
`define PGO_ADDR_NXA_A 16'hffa5
`define PGO_ADDR_NXB_B 16'hffa6
`define PGO_ADDR_NXA_B 16'hffa7

// ----------------------------------------------------------------
// Reset values and fixed read patterns
// ----------------------------------------------------------------
`define PGO_RST_MODE 4'h0
`define PGO_MODE_RSVD 4'hf
`define PGO_RST_TRIG 8'hff
`define PGO_RST_EN 8'h00
`define PGO_RST_NXT 8'h00
`define PGO_RST_PIN 4'h0
`define PGO_UNUSED 8'hff
`define PGO_NIB_ONES 4'hf
`define PGO_RD_IDLE 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PGO_SEL_G0 1:0
`define PGO_SEL_G1 3:2
`define PGO_SEL_G2 5:4
`define PGO_SEL_G3 7:6
`define PGO_NIB_HI 7:4
`define PGO_NIB_LO 3:0

// ----------------------------------------------------------------
// Group slices and non-overlap bits
// ----------------------------------------------------------------
`define PGO_GRP0 3:0
`define PGO_GRP1 7:4
`define PGO_GRP2 11:8
`define PGO_GRP3 15:12
`define PGO_BYTE_LO 7:0
`define PGO_BYTE_HI 15:8
`define PGO_NOV_G0 0
`define PGO_NOV_G1 1
`define PGO_NOV_G2 2
`define PGO_NOV_G3 3

// ----------------------------------------------------------------
// Timer channel codes
// ----------------------------------------------------------------
`define PGO_CH0 2'h0
`define PGO_CH1 2'h1
`define PGO_CH2 2'h2
`define PGO_CH3 2'h3

`endif

/* pgo_trig_sel.v */
`include "pgo_defines.vh"

module pgo_trig_sel (
    // Channel choice
    input wire [1:0] sel,
    // Timer compare matches, one bit per channel
    input wire [3:0] cmp_a,
    input wire [3:0] cmp_b,
    // Selected matches
    output reg trig_a,
    output reg trig_b
);

    always @* begin
        case (sel)
            `PGO_CH0: begin
                trig_a = cmp_a[0];
                trig_b = cmp_b[0];
            end
            `PGO_CH1: begin
                trig_a = cmp_a[1];
                trig_b = cmp_b[1];
            end
            `PGO_CH2: begin
                trig_a = cmp_a[2];
                trig_b = cmp_b[2];
            end
            default: begin
                trig_a = cmp_a[3];
                trig_b = cmp_b[3];
            end
        endcase
    end

endmodule // pgo_trig_sel

/* pgo_group.v */
`include "pgo_defines.vh"

module pgo_group (
    // Clock and reset
    input wire clock,
    input wire srst,
    // Staged data and controls
    input wire [3:0] nxt_data,
    input wire [3:0] enable,
    input wire nonoverlap,
    // Selected compare matches
    input wire trig_a,
    input wire trig_b,
    // Pin values
    output reg [3:0] pin_ff
);

    reg [3:0] set_mask;
    reg [3:0] clr_mask;
    reg [3:0] nxt_pin;

    always @* begin
        if (nonoverlap) begin
            // Falling bits at match B, rising bits at match A
            set_mask = {4{trig_a}} & enable & nxt_data;
            clr_mask = {4{trig_b}} & enable & ~nxt_data;
        end else begin
            set_mask = {4{trig_a}} & enable & nxt_data;
            clr_mask = {4{trig_a}} & enable & ~nxt_data;
        end
        nxt_pin = (pin_ff & ~clr_mask) | set_mask;
    end

    always @(posedge clock) begin
        if (srst) begin
            pin_ff <= `PGO_RST_PIN;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

endmodule // pgo_group

/* pond_asserts.sv */
module pgo_asserts (
    // Clock and reset
    input logic clock,
    input logic srst,
    // Register port
    input logic [15:0] addr,
    input logic [7:0] wr_data,
    input logic wr_stb,
    input logic rd_stb,
    input logic [7:0] rd_data_ff,
    // Matches and pins
    input logic [3:0] cmp_a,
    input logic [3:0] cmp_b,
    input logic [7:0] port_a_pin,
    input logic [7:0] port_b_pin,
    input logic [7:0] port_a_oe,
    input logic [7:0] port_b_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [7:0] sel_ff;
    logic sh01;
    logic sh23;
    // ----
    // Trigger select shadow
    // ----
    always_ff @(posedge clock) begin
        if (srst)
            sel_ff <= 8'hff;
        else if (wr_stb && addr == 16'h00a1)
            sel_ff <= wr_data;
    end
    assign sh01 = sel_ff[1:0] == sel_ff[3:2];
    assign sh23 = sel_ff[5:4] == sel_ff[7:6];
    sequence rd_at(logic [15:0] a);
        rd_stb && addr == a;
    endsequence
    // ----
    // Checks
    // ----
    en_wr_a: assert property (wr_stb && addr == 16'h00a3
        |=> port_a_oe == $past(wr_data)) else $error("enable write lost");
    en_rd_a: assert property (rd_at(16'h00a3)
        |=> rd_data_ff == port_a_oe) else $error("enable read wrong");
    sel_rd_a: assert property (rd_at(16'h00a1)
        |=> rd_data_ff == $past(sel_ff)) else $error("select read wrong");
    comp_hi_a: assert property (rd_at(16'hffa6) ##0 sh23
        |=> rd_data_ff == 8'hff) else $error("high companion not ones");
    comp_lo_a: assert property (rd_at(16'hffa7) ##0 sh01
        |=> rd_data_ff == 8'hff) else $error("low companion not ones");
    sep_lo_a: assert property ((rd_at(16'hffa4) ##0 !sh23)
        or (rd_at(16'hffa5) ##0 !sh01) |=> rd_data_ff[3:0] == 4'hf)
        else $error("unused low nibble not ones");
    sep_hi_a: assert property ((rd_at(16'hffa6) ##0 !sh23)
        or (rd_at(16'hffa7) ##0 !sh01) |=> rd_data_ff[7:4] == 4'hf)
        else $error("unused high nibble not ones");
    dis_hold_a: assert property (1'b1 |=> (({port_b_pin, port_a_pin}
        ^ $past({port_b_pin, port_a_pin}))
        & ~$past({port_b_oe, port_a_oe})) == 16'h0000)
        else $error("disabled pin changed");
    rise_cause_a: assert property (cmp_a == 4'h0
        |=> ({port_b_pin, port_a_pin} & ~$past({port_b_pin, port_a_pin}))
        == 16'h0000) else $error("pin rose without match A");
    pins_quiet_a: assert property (cmp_a == 4'h0 && cmp_b == 4'h0
        |=> $stable({port_b_pin, port_a_pin})) else $error("pin moved idle");
endmodule // pgo_asserts

/* pond_timer_model.sv */
module pgo_timer_model (
    // Clock
    input logic clock,
    // Match requests
    input logic [3:0] req_a,
    input logic [3:0] req_b,
    // One-cycle match pulses
    output logic [3:0] cmp_a,
    output logic [3:0] cmp_b
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clock) begin
        cmp_a <= req_a;
        cmp_b <= req_b;
    end
endmodule // pgo_timer_model

/* pond_tb_top.sv */
module pattern_output_next_data_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [3:0] req_a = 4'h0;
    logic [3:0] req_b = 4'h0;
    logic [7:0] rv;
    wire [7:0] rd_data_ff, port_a_pin, port_b_pin, port_a_oe, port_b_oe;
    wire [3:0] cmp_a, cmp_b;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    always #12.5 clock = ~clock;
    pgo_pattern_output dut_u (
        .clock(clock),
        .srst(srst),
        .addr(addr),
        .wr_data(wr_data),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rd_data_ff(rd_data_ff),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b),
        .port_a_pin(port_a_pin),
        .port_b_pin(port_b_pin),
        .port_a_oe(port_a_oe),
        .port_b_oe(port_b_oe)
    );
    pgo_timer_model tmr_u (
        .clock(clock),
        .req_a(req_a),
        .req_b(req_b),
        .cmp_a(cmp_a),
        .cmp_b(cmp_b)
    );
    // ----
    // Bus and match tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 rv = rd_data_ff;
    endtask
    task automatic fire(input logic [3:0] a, input logic [3:0] b);
        @(posedge clock);
        req_a <= a;
        req_b <= b;
        @(posedge clock);
        req_a <= 4'h0;
        req_b <= 4'h0;
        @(posedge clock);
        #1;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        logic [15:0] ra[6] = '{16'h00a3, 16'h00a1, 16'hffa4, 16'hffa6,
            16'hffa5, 16'hffa7};
        logic [7:0] re[6] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
        chk(port_a_oe, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            chk(rv, re[i]);
        end
    endtask
    task automatic t_shared;
        wr(16'h00a3, 8'ha5);
        rd(16'h00a3);
        chk(rv, 8'ha5);
        chk(port_a_oe, 8'ha5);
        wr(16'hffa5, 8'h3c);
        wr(16'hffa7, 8'h12);
        wr(16'h00a3, 8'h0f);
        rd(16'hffa7);
        chk(rv, 8'hff);
        fire(4'h8, 4'h0);
        chk(port_a_pin, 8'h0c);
        wr(16'hffa5, 8'hc3);
        fire(4'h7, 4'h0);
        chk(port_a_pin, 8'h0c);
        wr(16'h00a3, 8'hff);
        fire(4'h8, 4'h0);
        chk(port_a_pin, 8'hc3);
    endtask
    // Groups 0 and 1 on different channels, each channel in turn
    task automatic t_select;
        logic [1:0] c;
        logic [3:0] lo, hi;
        logic [7:0] p;
        p = 8'hc3;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            lo = {2'b10, c};
            hi = {c, 2'b01};
            wr(16'h00a1, {4'hf, c ^ 2'b01, c});
            wr(16'hffa5, {hi, 4'h0});
            wr(16'hffa7, {4'h0, lo});
            rd(16'hffa5);
            chk(rv, {hi, 4'hf});
            rd(16'hffa7);
            chk(rv, {4'hf, lo});
            fire(4'h1 << c, 4'h0);
            chk(port_a_pin, {p[7:4], lo});
            fire(4'h1 << (c ^ 2'b01), 4'h0);
            chk(port_a_pin, {hi, lo});
            p = {hi, lo};
        end
    endtask
    task automatic t_high;
        wr(16'h00a1, 8'h4f);
        wr(16'hffa4, 8'h9a);
        wr(16'hffa6, 8'h06);
        wr(16'h00a2, 8'hff);
        rd(16'hffa4);
        chk(rv, 8'h9f);
        chk(port_b_oe, 8'hff);
        rd(16'hffa6);
        chk(rv, 8'hf6);
        fire(4'h2, 4'h0);
        chk(port_b_pin, 8'h90);
        fire(4'h1, 4'h0);
        chk(port_b_pin, 8'h96);
        wr(16'h00a1, 8'hff);
        wr(16'hffa4, 8'h5e);
        fire(4'h8, 4'h0);
        chk(port_b_pin, 8'h5e);
    endtask
    task automatic t_nonov;
        wr(16'hffa5, 8'h00);
        fire(4'h8, 4'h0);
        wr(16'h00a0, 8'h01);
        rd(16'h00a0);
        chk(rv, 8'hf1);
        wr(16'hffa5, 8'h5a);
        fire(4'h0, 4'h8);
        chk(port_a_pin, 8'h00);
        fire(4'h8, 4'h0);
        chk(port_a_pin, 8'h5a);
        wr(16'hffa5, 8'h00);
        fire(4'h8, 4'h0);
        chk(port_a_pin, 8'h0a);
        fire(4'h0, 4'h8);
        chk(port_a_pin, 8'h00);
    endtask
    task automatic test_done;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_shared();
        t_select();
        t_high();
        t_nonov();
        test_done();
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end
endmodule // pattern_output_next_data_tb_top

bind pgo_pattern_output pgo_asserts chk_u (
    .clock(clock),
    .srst(srst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data_ff(rd_data_ff),
    .cmp_a(cmp_a),
    .cmp_b(cmp_b),
    .port_a_pin(port_a_pin),
    .port_b_pin(port_b_pin),
    .port_a_oe(port_a_oe),
    .port_b_oe(port_b_oe)
);
